// ---- design/tsf_cfg.svh ----
// constants of the temperature frame formatter: register offsets,
// field positions, reset values and message framing counts
// assumes byte addresses on an 8-bit slice of the bus address
`ifndef TSF_CFG_SVH
`define TSF_CFG_SVH

// =====================================================================
// register byte offsets
`define TSF_ADDR_CTRL 8'h00
`define TSF_ADDR_TEMP1 8'h04
`define TSF_ADDR_TEMP2 8'h08
`define TSF_ADDR_ERR 8'h0C
`define TSF_ADDR_SMSG 8'h10
`define TSF_ADDR_MUXWR 8'h14
`define TSF_ADDR_STAT 8'h18
`define TSF_ADDR_IRQ_STAT 8'h1C
`define TSF_ADDR_IRQ_MASK 8'h20

// =====================================================================
// field positions
`define TSF_CTRL_EN 0
`define TSF_CTRL_FMT_LO 1
`define TSF_CTRL_FMT_HI 2
`define TSF_CTRL_SMSG_EN 3
`define TSF_CTRL_MUXN_LO 4
`define TSF_CTRL_MUXN_HI 7
`define TSF_SMSG_ID_HI 7
`define TSF_SMSG_DATA_LO 8
`define TSF_SMSG_DATA_HI 19
`define TSF_SMSG_CRC_LO 20
`define TSF_SMSG_CRC_HI 25
`define TSF_MUXWR_IDX_LO 16
`define TSF_MUXWR_IDX_HI 19
`define TSF_IRQ_FRAME 0
`define TSF_IRQ_MSG 1
`define TSF_IRQ_CLAMP 2

// =====================================================================
// reset values
`define TSF_CTRL_RST 8'hF0
`define TSF_TEMP_RST 12'h000
`define TSF_SMSG_RST 26'h0
`define TSF_IRQ_RST 3'h0

// =====================================================================
// data limits and message framing
`define TSF_DATA_MIN 12'h001
`define TSF_DATA_MAX 12'hFF0
`define TSF_MSG_FRAMES 5'd18
`define TSF_MSG_SYNC 6'h3F

`endif

// ---- design/tsf_frame_formatter.sv ----
// temperature frame formatter: builds status and data nibbles per frame
// assumes an apb master on pclk and a nibble transmitter that pulses
// frame_req once per frame, synchronous to pclk
// =====================================================================
// What this block does
// - each sample is twelve bits in channel one
// - seven nibbles per frame (status and six data), six carrying data, four in multiplexed mode (two pad nibbles)
// - channel two: zeros, second temperature, or secure
// - multiplexed frames step control values ascending
// - status bits zero and one flag channel errors
// - multiplexed mode redefines status bits zero, one
// - status bits two, three carry optional messages
// - messages use 12-bit data, 8-bit identifier
// - extra data uses supplementary channel identifiers
// - ordinary samples avoid reserved signalling codes
// - primary temperature in channel one, except in multiplexed mode
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tsf_cfg.svh"
module tsf_frame_formatter import tsf_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // frame side
  input wire logic frame_req,
  output logic frame_valid,
  output logic [3:0] frame_status,
  output logic [23:0] frame_data,
  // interrupt
  output logic irq
);

  // =====================================================================
  // registers
  logic [7:0] ctrl_q;
  logic [11:0] temp1_q;
  logic [11:0] temp2_q;
  logic [1:0] err_q;
  logic [25:0] smsg_q;
  logic [11:0] mux_mem [16];
  logic [7:0] roll_q;
  logic [3:0] frame_control_value_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;
  logic frame_valid_q;
  logic [3:0] frame_status_q;
  logic [23:0] frame_data_q;
  logic irq_q;

  // decoded fields and strobes
  logic en;
  logic smsg_en;
  tsf_fmt_t fmt;
  logic [3:0] muxn;
  logic wr_en;
  logic rd_setup;
  logic accept;
  logic msg_bit2;
  logic msg_bit3;
  logic msg_busy;
  logic msg_done;
  logic [11:0] fc1_val;
  logic [11:0] fc2_val;
  logic [11:0] mux_val;
  logic clamp_hit;
  logic [3:0] status_d;
  logic [23:0] data_d;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;

  assign en = ctrl_q[`TSF_CTRL_EN];
  assign smsg_en = ctrl_q[`TSF_CTRL_SMSG_EN];
  assign fmt = tsf_fmt_t'(ctrl_q[`TSF_CTRL_FMT_HI:`TSF_CTRL_FMT_LO]);
  assign muxn = ctrl_q[`TSF_CTRL_MUXN_HI:`TSF_CTRL_MUXN_LO];
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign accept = frame_req & en;

  // keeps an ordinary sample out of the reserved codes
  function automatic logic [11:0] tsf_clamp(input logic [11:0] v);
    if (v < `TSF_DATA_MIN) begin
      return `TSF_DATA_MIN;
    end else if (v > `TSF_DATA_MAX) begin
      return `TSF_DATA_MAX;
    end
    return v;
  endfunction

  // true when a raw sample had to be moved into range
  function automatic logic tsf_out(input logic [11:0] v);
    return (v < `TSF_DATA_MIN) || (v > `TSF_DATA_MAX);
  endfunction

  // =====================================================================
  // apb control registers, written in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `TSF_CTRL_RST;
      temp1_q <= `TSF_TEMP_RST;
      temp2_q <= `TSF_TEMP_RST;
      err_q <= 2'h0;
      smsg_q <= `TSF_SMSG_RST;
      irq_mask_q <= `TSF_IRQ_RST;
    end else if (wr_en) begin
      unique case (paddr)
        `TSF_ADDR_CTRL: ctrl_q <= pwdata[7:0];
        `TSF_ADDR_TEMP1: temp1_q <= pwdata[11:0];
        `TSF_ADDR_TEMP2: temp2_q <= pwdata[11:0];
        `TSF_ADDR_ERR: err_q <= pwdata[1:0];
        `TSF_ADDR_SMSG: smsg_q <= pwdata[25:0];
        `TSF_ADDR_IRQ_MASK: irq_mask_q <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // multiplexed channel values, one word per frame control value
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == `TSF_ADDR_MUXWR) begin
      mux_mem[pwdata[`TSF_MUXWR_IDX_HI:`TSF_MUXWR_IDX_LO]] <=
        pwdata[11:0];
    end
  end

  // =====================================================================
  // read data captured in the setup phase, zero wait access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      pready_q <= 1'b1;
      if (rd_setup) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h00000000;
        unique case (paddr)
          `TSF_ADDR_CTRL: prdata_q <= {24'h000000, ctrl_q};
          `TSF_ADDR_TEMP1: prdata_q <= {20'h00000, temp1_q};
          `TSF_ADDR_TEMP2: prdata_q <= {20'h00000, temp2_q};
          `TSF_ADDR_ERR: prdata_q <= {30'h0, err_q};
          `TSF_ADDR_SMSG: prdata_q <= {6'h0, smsg_q};
          `TSF_ADDR_MUXWR: prdata_q <= 32'h00000000;
          `TSF_ADDR_STAT: begin
            prdata_q <= {19'h0, msg_busy, frame_control_value_q, roll_q};
          end
          `TSF_ADDR_IRQ_STAT: prdata_q <= {29'h0, irq_stat_q};
          `TSF_ADDR_IRQ_MASK: prdata_q <= {29'h0, irq_mask_q};
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // =====================================================================
  // serial message channel on status bits two and three
  tsf_serial_msg u_msg (
    .pclk(pclk),
    .presetn(presetn),
    .start(smsg_en & en & ~msg_busy),
    .msg_id(smsg_q[`TSF_SMSG_ID_HI:0]),
    .msg_data(smsg_q[`TSF_SMSG_DATA_HI:`TSF_SMSG_DATA_LO]),
    .msg_crc(smsg_q[`TSF_SMSG_CRC_HI:`TSF_SMSG_CRC_LO]),
    .frame_step(accept),
    .bit2(msg_bit2),
    .bit3(msg_bit3),
    .busy(msg_busy),
    .done(msg_done)
  );

  // =====================================================================
  // channel values for the next frame
  assign fc1_val = tsf_clamp(temp1_q);
  assign fc2_val = tsf_clamp(temp2_q);
  assign mux_val = tsf_clamp(mux_mem[frame_control_value_q]);

  // frame assembly per layout
  always_comb begin
    data_d = {fc1_val, 12'h000};
    status_d = {msg_bit3, msg_bit2, err_q[1], err_q[0]};
    clamp_hit = tsf_out(temp1_q);
    unique case (fmt)
      TSF_FMT_ZERO: data_d = {fc1_val, 12'h000};
      TSF_FMT_DUAL: begin
        data_d = {fc1_val, fc2_val};
        clamp_hit = tsf_out(temp1_q) | tsf_out(temp2_q);
      end
      TSF_FMT_SECURE: begin
        data_d = {fc1_val, roll_q, ~fc1_val[11:8]};
      end
      TSF_FMT_MUX: begin
        // control value, pad, 12-bit data in nibbles three to five, pad
        data_d = {frame_control_value_q, 4'h0, mux_val, 4'h0};
        status_d = {msg_bit3, msg_bit2, err_q[0],
                    (frame_control_value_q == 4'h0)};
        clamp_hit = tsf_out(mux_mem[frame_control_value_q]);
      end
    endcase
  end

  // frame outputs, one frame per accepted request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_valid_q <= 1'b0;
      frame_status_q <= 4'h0;
      frame_data_q <= 24'h000000;
    end else begin
      frame_valid_q <= accept;
      if (accept) begin
        frame_status_q <= status_d;
        frame_data_q <= data_d;
      end
    end
  end

  assign frame_valid = frame_valid_q;
  assign frame_status = frame_status_q;
  assign frame_data = frame_data_q;

  // rolling counter advances once per secure frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roll_q <= 8'h00;
    end else if (accept && fmt == TSF_FMT_SECURE) begin
      roll_q <= roll_q + 8'h01;
    end
  end

  // frame control value wraps after the last configured one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_control_value_q <= 4'h0;
    end else if (fmt != TSF_FMT_MUX) begin
      frame_control_value_q <= 4'h0;
    end else if (accept) begin
      frame_control_value_q <= (frame_control_value_q >= muxn) ?
        4'h0 : frame_control_value_q + 4'h1;
    end
  end

  // =====================================================================
  // sticky events, write one to clear, a set wins over the clear
  assign irq_set = {accept & clamp_hit, msg_done, accept};
  assign irq_clr = (wr_en && paddr == `TSF_ADDR_IRQ_STAT) ?
                   pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `TSF_IRQ_RST;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  // level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign irq = irq_q;

  // =====================================================================
  // checks
  property p_fc1_temp;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt != TSF_FMT_MUX) |=>
        frame_data[23:12] == tsf_clamp($past(temp1_q));
  endproperty
  a_fc1_temp: assert property (p_fc1_temp)
    else $error("channel one does not hold the primary temperature");

  property p_zero_fill;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt == TSF_FMT_ZERO) |=> frame_data[11:0] == 12'h000;
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("channel two not zero filled");

  property p_secure_inv;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt == TSF_FMT_SECURE) |=>
        frame_data[3:0] == ~frame_data[23:20] &&
        frame_data[11:4] == $past(roll_q);
  endproperty
  a_secure_inv: assert property (p_secure_inv)
    else $error("secure channel two malformed");

  property p_roll_step;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt == TSF_FMT_SECURE) |=>
        roll_q == $past(roll_q) + 8'h01;
  endproperty
  a_roll_step: assert property (p_roll_step)
    else $error("rolling counter did not advance");

  property p_mux_order;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt == TSF_FMT_MUX && frame_control_value_q < muxn) ##1
        (fmt == TSF_FMT_MUX) |->
        frame_data[23:20] == $past(frame_control_value_q) &&
        frame_control_value_q == $past(frame_control_value_q) + 4'h1;
  endproperty
  a_mux_order: assert property (p_mux_order)
    else $error("frame control values not ascending");

  property p_err_bits;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt != TSF_FMT_MUX) |=>
        frame_status[1:0] == $past(err_q);
  endproperty
  a_err_bits: assert property (p_err_bits)
    else $error("status error bits do not follow channel errors");

  property p_mux_status;
    @(posedge pclk) disable iff (!presetn)
      (accept && fmt == TSF_FMT_MUX) |=>
        frame_status[0] == ($past(frame_control_value_q) == 4'h0);
  endproperty
  a_mux_status: assert property (p_mux_status)
    else $error("multiplexed status bit zero wrong");

  property p_no_msg;
    @(posedge pclk) disable iff (!presetn)
      (accept && !msg_busy) |=> frame_status[3:2] == 2'b00;
  endproperty
  a_no_msg: assert property (p_no_msg)
    else $error("message bits set with no message running");

  property p_range;
    @(posedge pclk) disable iff (!presetn)
      accept |=> (($past(fmt) == TSF_FMT_MUX) ? frame_data[15:4] :
        frame_data[23:12]) inside {[`TSF_DATA_MIN:`TSF_DATA_MAX]};
  endproperty
  a_range: assert property (p_range)
    else $error("reserved code sent as a sample");

endmodule

// ---- design/tsf_pkg.sv ----
// types of the temperature frame formatter
// assumes nothing of its surroundings
package tsf_pkg;

  // =====================================================================
  // frame layouts selected by software
  typedef enum logic [1:0] {
    TSF_FMT_ZERO = 2'h0,
    TSF_FMT_DUAL = 2'h1,
    TSF_FMT_SECURE = 2'h2,
    TSF_FMT_MUX = 2'h3
  } tsf_fmt_t;

  // =====================================================================
  // serial message sequencer states
  typedef enum logic [1:0] {
    TSF_MS_IDLE = 2'b01,
    TSF_MS_SEND = 2'b10
  } tsf_msg_state_t;

endpackage

// ---- design/tsf_serial_msg.sv ----
// enhanced serial message sequencer: bits 2 and 3 of the status nibble
// assumes one frame_step pulse per frame sent, in the pclk domain
`timescale 1ns/1ps
`include "tsf_cfg.svh"
module tsf_serial_msg import tsf_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // message content and control
  input wire logic start,
  input wire logic [7:0] msg_id,
  input wire logic [11:0] msg_data,
  input wire logic [5:0] msg_crc,
  input wire logic frame_step,
  // nibble bits and progress
  output logic bit2,
  output logic bit3,
  output logic busy,
  output logic done
);

  tsf_msg_state_t state_q;
  logic [17:0] sh2_q;
  logic [17:0] sh3_q;
  logic [4:0] left_q;

  // =====================================================================
  // load both bit streams, then shift one bit per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= TSF_MS_IDLE;
      sh2_q <= 18'h0;
      sh3_q <= 18'h0;
      left_q <= 5'd0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_q)
        TSF_MS_IDLE: begin
          if (start) begin
            // sync ones, then 8-bit id and 12-bit data, config bit 0
            sh3_q <= {`TSF_MSG_SYNC, 2'b00, msg_id[7:4], 1'b0,
                      msg_id[3:0], 1'b0};
            sh2_q <= {msg_crc, msg_data};
            left_q <= `TSF_MSG_FRAMES;
            state_q <= TSF_MS_SEND;
          end
        end
        TSF_MS_SEND: begin
          if (frame_step) begin
            sh2_q <= {sh2_q[16:0], 1'b0};
            sh3_q <= {sh3_q[16:0], 1'b0};
            left_q <= left_q - 5'd1;
            if (left_q == 5'd1) begin
              state_q <= TSF_MS_IDLE;
              done <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // current frame bits, zero while idle
  assign busy = (state_q == TSF_MS_SEND);
  assign bit2 = busy & sh2_q[17];
  assign bit3 = busy & sh3_q[17];

  property p_msg_sync;
    @(posedge pclk) disable iff (!presetn)
      (start && state_q == TSF_MS_IDLE) |=> bit3 && left_q == 5'd18;
  endproperty
  a_msg_sync: assert property (p_msg_sync)
    else $error("message does not open with sync bit");

endmodule

// ---- test/test_temp_sensor_frame_formatter.sv ----
// self-checking bench of the frame formatter over apb and frame side
// assumes the formatter, its package and the receiver model
`timescale 1ns/1ps
`include "tsf_cfg.svh"
module test_temp_sensor_frame_formatter import tsf_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic frame_req, frame_valid, go, secure, slv;
  logic [3:0] rx_status, frame_status;
  logic [23:0] rx_data, frame_data;
  logic [7:0] frames, sec_err;
  logic [17:0] b3, b2;
  int err_total, compares;

  // =====================================================================
  // clock, design and receiver
  always #2 pclk = ~pclk;

  tsf_frame_formatter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_req(frame_req), .frame_valid(frame_valid),
    .frame_status(frame_status), .frame_data(frame_data), .irq(irq));

  tsf_rx_model rx (.pclk(pclk), .presetn(presetn), .go(go),
    .secure(secure), .frame_req(frame_req), .frame_valid(frame_valid),
    .frame_status(frame_status), .frame_data(frame_data),
    .rx_status(rx_status), .rx_data(rx_data), .frames(frames),
    .sec_err(sec_err));

  // =====================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) chk(32'h0, 32'h1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // ask the receiver for one frame and wait for its capture
  task automatic frm();
    int n;
    logic [7:0] f0;
    f0 = frames;
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    while (frames === f0 && n < 16) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // =====================================================================
  // watchdog
  initial begin
    #40000;
    err_total++;
    conclude();
  end

  // =====================================================================
  // tests
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, go, secure} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped and write-only places
    rd(`TSF_ADDR_CTRL, {24'h0, `TSF_CTRL_RST});
    rd(`TSF_ADDR_TEMP1, 32'h0);
    rd(`TSF_ADDR_IRQ_STAT, 32'h0);
    rd(8'h24, 32'h0);
    chk({31'h0, slv}, 32'h1);
    wr(`TSF_ADDR_MUXWR, 32'h00000ABC);
    rd(`TSF_ADDR_MUXWR, 32'h0);
    // disabled: request ignored
    frm();
    chk({24'h0, frames}, 32'h0);
    $display("test reset_map done");
    // dual, error flags, zero fill
    wr(`TSF_ADDR_TEMP1, 32'h123);
    wr(`TSF_ADDR_TEMP2, 32'h456);
    wr(`TSF_ADDR_CTRL, 32'hF3);
    frm();
    chk({8'h0, rx_data}, 32'h123456);
    chk({28'h0, rx_status}, 32'h0);
    wr(`TSF_ADDR_ERR, 32'h1);
    frm();
    chk({30'h0, rx_status[1:0]}, 32'h1);
    wr(`TSF_ADDR_ERR, 32'h2);
    frm();
    chk({30'h0, rx_status[1:0]}, 32'h2);
    wr(`TSF_ADDR_ERR, 32'h0);
    wr(`TSF_ADDR_CTRL, 32'hF1);
    frm();
    chk({8'h0, rx_data}, 32'h123000);
    // reserved codes clamped
    wr(`TSF_ADDR_IRQ_STAT, 32'h7);
    wr(`TSF_ADDR_TEMP1, 32'h000);
    frm();
    chk({20'h0, rx_data[23:12]}, 32'h001);
    rd(`TSF_ADDR_IRQ_STAT, 32'h5);
    wr(`TSF_ADDR_TEMP1, 32'hFFF);
    frm();
    chk({20'h0, rx_data[23:12]}, 32'hFF0);
    $display("test formats done");
    // secure: counter steps, inverted top nibble
    wr(`TSF_ADDR_TEMP1, 32'hABC);
    secure <= 1'b1;
    wr(`TSF_ADDR_CTRL, 32'hF5);
    repeat (3) frm();
    chk({20'h0, rx_data[23:12]}, 32'hABC);
    chk({28'h0, rx_data[3:0]}, 32'h5);
    chk({24'h0, sec_err}, 32'h0);
    rd(`TSF_ADDR_STAT, 32'h3);
    secure <= 1'b0;
    $display("test secure done");
    // mux: control values 0,1 then wrap
    wr(`TSF_ADDR_MUXWR, 32'h00000111);
    wr(`TSF_ADDR_MUXWR, 32'h00010222);
    wr(`TSF_ADDR_CTRL, 32'h17);
    for (int i = 0; i < 3; i++) begin
      frm();
      chk({8'h0, rx_data}, (i == 1) ? 32'h102220 : 32'h001110);
      chk({31'h0, rx_status[0]}, (i == 1) ? 32'h0 : 32'h1);
    end
    rd(`TSF_ADDR_STAT, 32'h103);
    $display("test mux done");
    // interrupt raised, cleared, masked
    wr(`TSF_ADDR_CTRL, 32'hF3);
    wr(`TSF_ADDR_IRQ_STAT, 32'h7);
    wr(`TSF_ADDR_IRQ_MASK, 32'h1);
    frm();
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd(`TSF_ADDR_IRQ_STAT, 32'h1);
    wr(`TSF_ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wr(`TSF_ADDR_IRQ_MASK, 32'h0);
    frm();
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
    // enhanced serial message over 18 frames
    wr(`TSF_ADDR_IRQ_STAT, 32'h7);
    wr(`TSF_ADDR_SMSG, 32'h02A123A5);
    rd(`TSF_ADDR_SMSG, 32'h02A123A5);
    wr(`TSF_ADDR_IRQ_MASK, 32'h2);
    wr(`TSF_ADDR_CTRL, 32'hFB);
    for (int i = 0; i < 18; i++) begin
      frm();
      b3 = {b3[16:0], rx_status[3]};
      b2 = {b2[16:0], rx_status[2]};
    end
    wr(`TSF_ADDR_CTRL, 32'hF3);
    chk({14'h0, b3}, {14'h0, 6'h3F, 2'b00, 4'hA, 1'b0, 4'h5, 1'b0});
    chk({14'h0, b2}, {14'h0, 6'h2A, 12'h123});
    rd(`TSF_ADDR_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    $display("test serial done");
    chk({24'h0, frames}, 32'h20);
    conclude();
  end
endmodule

// ---- test/tsf_rx_model.sv ----
// receiver model: requests frames and captures the nibbles sent back
// assumes the formatter's one-cycle frame_valid pulse on pclk
`timescale 1ns/1ps
module tsf_rx_model import tsf_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from bench
  input wire logic go,
  input wire logic secure,
  // frame side
  output logic frame_req,
  input wire logic frame_valid,
  input wire logic [3:0] frame_status,
  input wire logic [23:0] frame_data,
  // decoded view
  output logic [3:0] rx_status,
  output logic [23:0] rx_data,
  output logic [7:0] frames,
  output logic [7:0] sec_err
);
  logic [7:0] cnt_q;
  logic seen_q;

  // =====================================================================
  // request: one pulse per go cycle, low between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_req <= 1'b0;
    end else begin
      frame_req <= go;
    end
  end

  // capture each frame; secure counter must step, top nibble inverted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_status <= 4'h0;
      rx_data <= 24'h000000;
      frames <= 8'h00;
      sec_err <= 8'h00;
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
    end else if (frame_valid) begin
      rx_status <= frame_status;
      rx_data <= frame_data;
      frames <= frames + 8'h01;
      seen_q <= secure;
      cnt_q <= frame_data[11:4];
      if (secure && ((frame_data[3:0] !== ~frame_data[23:20]) ||
          (seen_q && (frame_data[11:4] !== cnt_q + 8'h01)))) begin
        sec_err <= sec_err + 8'h01;
      end
    end
  end
endmodule
